// [dip_params.svh]
// Constants for the supply-dip ride-through block: register map, field
// layout, reset values and timing. Included by the tick, ramp and supervisor files.
`ifndef DIP_PARAMS_SVH
`define DIP_PARAMS_SVH

`define CLK_HZ              50000000
`define MS_PER_S            1000
`define CYC_PER_MS          (`CLK_HZ / `MS_PER_S)

// Register byte offsets
`define OFF_CTRL            12'h000
`define OFF_HOLD            12'h004
`define OFF_MAXSPD          12'h008
`define OFF_UVMODE          12'h00c
`define OFF_DIPLIM          12'h010
`define OFF_RELTIME         12'h014
`define OFF_NORMLIM         12'h018
`define OFF_STATUS          12'h01c
`define OFF_FLIM            12'h020

// Ranges and reset values
`define HOLD_MIN            16'd20
`define HOLD_MAX            16'd1000
`define HOLD_RST            16'd20
`define MAXSPD_MIN          8'd1
`define MAXSPD_MAX          8'd100
`define MAXSPD_RST          8'd50
`define UVMODE_RST          2'd0
`define DIPLIM_MAX          8'd100
`define DIPLIM_RST          8'd50
`define RELTIME_MAX         16'd1000
`define RELTIME_RST         16'd100
`define NORMLIM_RST         8'd100
// Fixed overload trip level, not reachable from software
`define OVLD_HIGH_LEVEL     8'd200

// Status register bit positions
`define ST_READY            0
`define ST_POWER            1
`define ST_UVWARN           2
`define ST_UVALARM          3
`define ST_OVSPD            4
`define ST_OVLD             5
`define ST_CUT              6

`endif

// [dip_pkg.sv]
// Types shared by the supply-dip ride-through block.
// Assumes dip_params.svh supplies the numeric constants.
package dip_pkg;
    typedef enum logic [1:0] {
        UV_OFF,
        UV_HOST,
        UV_INTERNAL,
        UV_RSVD
    } uv_mode_t;

    typedef enum {
        ST_RUN,
        ST_DIP,
        ST_CUT
    } dip_state_t;
endpackage

// [ms_tick.sv]
// Millisecond tick generator.
// Assumes clock_i at the rate given in dip_params.svh.
`timescale 1ns/10ps
`include "dip_params.svh"
module ms_tick #(
    parameter int CYCLES = `CYC_PER_MS
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    output logic      tick_o
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        tick_reg;
    logic        tick_next;

    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (cnt_reg == 32'(CYCLES - 1)) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (ce_i) begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg & ce_i;
endmodule

// [force_ramp.sv]
// Force-limit ramp: clamps to the dip limit, then climbs back linearly.
// Assumes a one-cycle millisecond tick on the same clock.
`timescale 1ns/10ps
`include "dip_params.svh"
module force_ramp (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       ms_tick_i,
    input  wire logic       enable_i,
    input  wire logic       warn_i,
    input  wire logic [7:0] dip_lim_i,
    input  wire logic [7:0] norm_lim_i,
    input  wire logic [15:0] rel_ms_i,
    output logic [7:0]      limit_o
);
    logic [15:0] elapsed_reg;
    logic [15:0] elapsed_next;
    logic        ramp_reg;
    logic        ramp_next;
    logic [7:0]  lim_reg;
    logic [7:0]  lim_next;
    logic [7:0]  span;
    logic [23:0] step;

    always_comb begin
        elapsed_next = elapsed_reg;
        ramp_next    = ramp_reg;
        span         = (norm_lim_i > dip_lim_i) ?
                       8'(norm_lim_i - dip_lim_i) : 8'h00;
        step         = 24'h0;
        lim_next     = norm_lim_i;
        if (!enable_i) begin
            ramp_next    = 1'b0;
            elapsed_next = '0;
        end else if (warn_i) begin
            // Clamp while the warning stands
            ramp_next    = 1'b1;
            elapsed_next = '0;
            lim_next     = (dip_lim_i < norm_lim_i) ? dip_lim_i : norm_lim_i;
        end else if (ramp_reg) begin
            // Release time is read live, so a change acts at once
            if (elapsed_reg >= rel_ms_i) begin
                ramp_next = 1'b0;
            end else begin
                // Linear climb from the dip limit
                step = (24'(span) * 24'(elapsed_reg)) / 24'(rel_ms_i);
                lim_next = 8'(dip_lim_i + step[7:0]);
                if (ms_tick_i) begin
                    elapsed_next = elapsed_reg + 16'h1;
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            elapsed_reg <= '0;
            ramp_reg    <= 1'b0;
            lim_reg     <= `NORMLIM_RST;
        end else if (ce_i) begin
            elapsed_reg <= elapsed_next;
            ramp_reg    <= ramp_next;
            lim_reg     <= lim_next;
        end
    end

    assign limit_o = lim_reg;
endmodule

// [power_dip_ride_through.sv]
// Main-circuit supply dip supervisor with APB register access.
// Assumes supply and speed inputs arrive asynchronously from sensing logic.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "dip_params.svh"

// Notes on behaviour
// - Hold time 20..1000 ms, default 20, acts immediately.
// - Dip shorter than hold time: motor keeps running.
// - Dip longer: power off until supply returns, then back on.
// - Dip longer than hold time drops servo-ready.
// - Undervoltage alarm during dip ignores the hold time.
// - Control supply loss acts as normal power-off, ignoring hold time.
// - Max speed 1..100 x100 mm/s, default 50, at restart; overspeed alarm.
// - Mode 0 no detection, 1 host limits, 2 internal limits; at restart.
// - Internal mode clamps force, then releases over release time.
// - Dip force limit 0..100 percent, default 50, acts immediately.
// - Release time 0..1000 ms, default 100, acts immediately.
// - Servo-off command cuts motor current at once.
// - High-load overload level is fixed, not settable.
module power_dip_ride_through
    import dip_pkg::*;
#(
    parameter int MS_CYCLES = `CYC_PER_MS
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mains_ok_i,
    input  wire logic        ctrl_supply_ok_i,
    input  wire logic        bus_below_low_i,
    input  wire logic        bus_above_high_i,
    input  wire logic        uv_alarm_i,
    input  wire logic [7:0]  speed_i,
    input  wire logic [7:0]  load_i,
    input  wire logic        servo_off_command_i,
    output logic             servo_ready_o,
    output logic             motor_power_o,
    output logic             uv_warning_o,
    output logic             overspeed_alarm_o,
    output logic             overload_alarm_o,
    output logic [7:0]       force_limit_o
);
    // Two-flop synchronisers for every off-domain input
    localparam int NSYNC = 22;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;
    assign raw_in = {load_i, speed_i, servo_off_command_i, uv_alarm_i,
                     bus_above_high_i, bus_below_low_i, ctrl_supply_ok_i,
                     mains_ok_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                end else if (ce_i) begin
                    s1_reg[gi] <= raw_in[gi];
                    s2_reg[gi] <= s1_reg[gi];
                end
            end
        end
    endgenerate

    logic       mains_ok;
    logic       ctrl_ok;
    logic       bus_low;
    logic       bus_high;
    logic       uv_alarm;
    logic       svoff;
    logic [7:0] speed;
    logic [7:0] load;
    assign mains_ok = s2_reg[0];
    assign ctrl_ok  = s2_reg[1];
    assign bus_low  = s2_reg[2];
    assign bus_high = s2_reg[3];
    assign uv_alarm = s2_reg[4];
    assign svoff    = s2_reg[5];
    assign speed    = s2_reg[13:6];
    assign load     = s2_reg[21:14];

    // Settings
    logic [15:0] hold_reg, hold_next;
    logic [7:0]  maxspd_reg, maxspd_next;
    logic [1:0]  uvmode_reg, uvmode_next;
    logic [7:0]  diplim_reg, diplim_next;
    logic [15:0] rel_reg, rel_next;
    logic [7:0]  normlim_reg, normlim_next;
    logic        restart_req;
    // Values latched at restart
    logic [7:0]  maxspd_act_reg, maxspd_act_next;
    uv_mode_t    uvmode_act_reg, uvmode_act_next;

    logic        wr_en;
    logic        rd_hit;
    logic [31:0] rd_data;
    logic [31:0] status_word;
    logic [7:0]  ramp_limit;

    assign wr_en  = psel & penable & pwrite;
    assign pready = 1'b1;

    always_comb begin
        hold_next    = hold_reg;
        maxspd_next  = maxspd_reg;
        uvmode_next  = uvmode_reg;
        diplim_next  = diplim_reg;
        rel_next     = rel_reg;
        normlim_next = normlim_reg;
        restart_req  = 1'b0;
        if (wr_en) begin
            case (paddr)
                `OFF_CTRL: restart_req = pwdata[0];
                `OFF_HOLD: begin
                    // Out-of-range values are clamped into range
                    if (pwdata[31:16] != '0 || pwdata[15:0] > `HOLD_MAX)
                        hold_next = `HOLD_MAX;
                    else if (pwdata[15:0] < `HOLD_MIN)
                        hold_next = `HOLD_MIN;
                    else
                        hold_next = pwdata[15:0];
                end
                `OFF_MAXSPD: begin
                    if (pwdata[31:8] != '0 || pwdata[7:0] > `MAXSPD_MAX)
                        maxspd_next = `MAXSPD_MAX;
                    else if (pwdata[7:0] < `MAXSPD_MIN)
                        maxspd_next = `MAXSPD_MIN;
                    else
                        maxspd_next = pwdata[7:0];
                end
                `OFF_UVMODE: uvmode_next = pwdata[1:0];
                `OFF_DIPLIM: begin
                    if (pwdata[31:8] != '0 || pwdata[7:0] > `DIPLIM_MAX)
                        diplim_next = `DIPLIM_MAX;
                    else
                        diplim_next = pwdata[7:0];
                end
                `OFF_RELTIME: begin
                    if (pwdata[31:16] != '0 ||
                        pwdata[15:0] > `RELTIME_MAX)
                        rel_next = `RELTIME_MAX;
                    else
                        rel_next = pwdata[15:0];
                end
                `OFF_NORMLIM: normlim_next = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        maxspd_act_next = maxspd_act_reg;
        uvmode_act_next = uvmode_act_reg;
        if (restart_req) begin
            // Speed limit and mode take effect only at restart
            maxspd_act_next = maxspd_reg;
            uvmode_act_next = (uvmode_reg == 2'd3) ? UV_OFF :
                              uv_mode_t'(uvmode_reg);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hold_reg       <= `HOLD_RST;
            maxspd_reg     <= `MAXSPD_RST;
            uvmode_reg     <= `UVMODE_RST;
            diplim_reg     <= `DIPLIM_RST;
            rel_reg        <= `RELTIME_RST;
            normlim_reg    <= `NORMLIM_RST;
            maxspd_act_reg <= `MAXSPD_RST;
            uvmode_act_reg <= UV_OFF;
        end else if (ce_i) begin
            hold_reg       <= hold_next;
            maxspd_reg     <= maxspd_next;
            uvmode_reg     <= uvmode_next;
            diplim_reg     <= diplim_next;
            rel_reg        <= rel_next;
            normlim_reg    <= normlim_next;
            maxspd_act_reg <= maxspd_act_next;
            uvmode_act_reg <= uvmode_act_next;
        end
    end

    logic ms_tick;
    ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .tick_o  (ms_tick)
    );

    // Supply dip state machine
    dip_state_t  state_reg, state_next;
    logic [15:0] dip_ms_reg, dip_ms_next;
    logic        ready_reg, ready_next;
    logic        power_reg, power_next;
    logic        warn_reg, warn_next;
    logic        ovspd_reg, ovspd_next;
    logic        ovld_reg, ovld_next;

    always_comb begin
        state_next  = state_reg;
        dip_ms_next = dip_ms_reg;
        ready_next  = ready_reg;
        power_next  = power_reg;
        case (state_reg)
            ST_RUN: begin
                dip_ms_next = '0;
                ready_next  = 1'b1;
                power_next  = 1'b1;
                if (!mains_ok)
                    state_next = ST_DIP;
            end
            ST_DIP: begin
                // Ride through while within hold time
                if (mains_ok) begin
                    state_next = ST_RUN;
                end else if (dip_ms_reg >= hold_reg ||
                             uv_alarm) begin
                    // Hold time read live alarm overrides it
                    state_next = ST_CUT;
                end else if (ms_tick) begin
                    dip_ms_next = dip_ms_reg + 16'h1;
                end
            end
            ST_CUT: begin
                power_next = 1'b0;
                ready_next = 1'b0;
                if (mains_ok)
                    state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
        // Control loss: plain power-off, hold time ignored
        if (!ctrl_ok) begin
            state_next = ST_CUT;
            power_next = 1'b0;
            ready_next = 1'b0;
        end
    end

    always_comb begin
        warn_next = warn_reg;
        // Hysteresis on the DC bus
        if (uvmode_act_reg == UV_OFF)
            warn_next = 1'b0;
        else if (bus_low)
            warn_next = 1'b1;
        else if (bus_high)
            warn_next = 1'b0;
        ovspd_next = ovspd_reg | (speed > maxspd_act_reg);
        // Fixed level, no register reaches it
        ovld_next  = ovld_reg | (load > `OVLD_HIGH_LEVEL);
        // A trip in the restart cycle wins over the clear
        if (restart_req) begin
            ovspd_next = (speed > maxspd_act_reg);
            ovld_next  = (load > `OVLD_HIGH_LEVEL);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg  <= ST_RUN;
            dip_ms_reg <= '0;
            ready_reg  <= 1'b0;
            power_reg  <= 1'b0;
            warn_reg   <= 1'b0;
            ovspd_reg  <= 1'b0;
            ovld_reg   <= 1'b0;
        end else if (ce_i) begin
            state_reg  <= state_next;
            dip_ms_reg <= dip_ms_next;
            ready_reg  <= ready_next;
            power_reg  <= power_next;
            warn_reg   <= warn_next;
            ovspd_reg  <= ovspd_next;
            ovld_reg   <= ovld_next;
        end
    end

    force_ramp u_ramp (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .ms_tick_i  (ms_tick),
        .enable_i   (uvmode_act_reg == UV_INTERNAL),
        .warn_i     (warn_reg),
        .dip_lim_i  (diplim_reg),
        .norm_lim_i (normlim_reg),
        .rel_ms_i   (rel_reg),
        .limit_o    (ramp_limit)
    );

    // Servo-off gates current straight away, bypassing the hold timer
    assign motor_power_o     = power_reg & ~svoff;
    assign servo_ready_o     = ready_reg;
    assign uv_warning_o      = warn_reg;
    assign overspeed_alarm_o = ovspd_reg;
    assign overload_alarm_o  = ovld_reg;
    assign force_limit_o     = ramp_limit;

    always_comb begin
        status_word = '0;
        status_word[`ST_READY]   = ready_reg;
        status_word[`ST_POWER]   = motor_power_o;
        status_word[`ST_UVWARN]  = warn_reg;
        status_word[`ST_UVALARM] = uv_alarm;
        status_word[`ST_OVSPD]   = ovspd_reg;
        status_word[`ST_OVLD]    = ovld_reg;
        status_word[`ST_CUT]     = (state_reg == ST_CUT);
        rd_hit  = 1'b1;
        rd_data = '0;
        case (paddr)
            `OFF_CTRL:    rd_data = '0;
            `OFF_HOLD:    rd_data = 32'(hold_reg);
            `OFF_MAXSPD:  rd_data = 32'(maxspd_reg);
            `OFF_UVMODE:  rd_data = 32'(uvmode_reg);
            `OFF_DIPLIM:  rd_data = 32'(diplim_reg);
            `OFF_RELTIME: rd_data = 32'(rel_reg);
            `OFF_NORMLIM: rd_data = 32'(normlim_reg);
            `OFF_STATUS:  rd_data = status_word;
            `OFF_FLIM:    rd_data = 32'(ramp_limit);
            default:      rd_hit  = 1'b0;
        endcase
    end

    logic [31:0] prdata_reg, prdata_next;
    always_comb begin
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite)
            prdata_next = rd_data;
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)
            prdata_reg <= '0;
        else if (ce_i)
            prdata_reg <= prdata_next;
    end
    assign prdata  = prdata_reg;
    assign pslverr = psel & penable & ~rd_hit;
endmodule

// [dip_checker.sv]
// Port-level checker for the supply-dip supervisor.
// Assumes ce_i is held high; watches only the top module's ports.
`timescale 1ns/10ps
module dip_checker (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pslverr,
    input wire logic        mains_ok_i,
    input wire logic        ctrl_supply_ok_i,
    input wire logic        bus_above_high_i,
    input wire logic        uv_alarm_i,
    input wire logic [7:0]  speed_i,
    input wire logic [7:0]  load_i,
    input wire logic        servo_off_command_i,
    input wire logic        servo_ready_o,
    input wire logic        motor_power_o,
    input wire logic        uv_warning_o,
    input wire logic        overspeed_alarm_o,
    input wire logic        overload_alarm_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Margins cover the two-flop input synchronisers
    a_stop_cuts_power: assert property (
        servo_off_command_i [*2] |=> !motor_power_o)
        else $error("power on after stop");
    a_cut_drops_both: assert property (
        $fell(servo_ready_o) |-> !motor_power_o)
        else $error("ready fell, power on");
    a_ctrl_loss_cuts: assert property (
        !ctrl_supply_ok_i [*4] |=> !servo_ready_o && !motor_power_o)
        else $error("ctrl loss no cut");
    a_uv_alarm_cuts: assert property (
        (!mains_ok_i && uv_alarm_i) [*6] |=> !servo_ready_o)
        else $error("alarm dip no cut");
    a_supply_restores: assert property (
        (mains_ok_i && ctrl_supply_ok_i && !servo_off_command_i) [*8]
        |=> motor_power_o && servo_ready_o)
        else $error("power not restored");
    a_overspeed_trips: assert property (
        (speed_i > 8'd100) [*3] |=> overspeed_alarm_o)
        else $error("no overspeed alarm");
    a_overload_fixed: assert property (
        (load_i > 8'd200) [*3] |=> overload_alarm_o)
        else $error("no overload alarm");
    a_warn_clears: assert property (
        bus_above_high_i [*4] |=> !uv_warning_o)
        else $error("warning not cleared");
    a_unmapped_err: assert property (
        psel && penable && paddr > 12'h020 |-> pslverr)
        else $error("no slave error");

    c_cut: cover property ($fell(servo_ready_o));
    c_warn: cover property ($rose(uv_warning_o));
    c_ovspd: cover property ($rose(overspeed_alarm_o));
endmodule

bind power_dip_ride_through dip_checker u_chk (
    .clock_i, .rst_n_i, .psel, .penable, .paddr, .pslverr, .mains_ok_i,
    .ctrl_supply_ok_i, .bus_above_high_i, .uv_alarm_i, .speed_i, .load_i,
    .servo_off_command_i, .servo_ready_o, .motor_power_o, .uv_warning_o,
    .overspeed_alarm_o, .overload_alarm_o);

// [host_model.sv]
// Host motion controller model: stop command and warning force limit.
// Assumes it shares the drive's clock and synchronous active-low reset.
`timescale 1ns/10ps
module host_model #(
    parameter logic [7:0] HOST_LIMIT = 8'h28
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic uv_warning_i,
    input  wire logic stop_req_i,
    output logic       servo_off_command_o,
    output logic [7:0] host_limit_o
);
    logic       stop_reg;
    logic       stop_next;
    logic [7:0] limit_reg;
    logic [7:0] limit_next;

    always_comb begin
        stop_next = stop_req_i;
        // Limit only while warned, so restore sees no surge
        limit_next = uv_warning_i ? HOST_LIMIT : 8'h64;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            stop_reg  <= 1'b0;
            limit_reg <= 8'h64;
        end else begin
            stop_reg  <= stop_next;
            limit_reg <= limit_next;
        end
    end

    assign servo_off_command_o = stop_reg;
    assign host_limit_o        = limit_reg;
endmodule

// [power_dip_ride_through_tb.sv]
// Self-checking bench for the supply-dip supervisor over APB.
// Assumes a 10-cycle millisecond so hold and ramp times stay short.
`timescale 1ns/10ps
`include "dip_params.svh"
module power_dip_ride_through_tb;
    localparam int MSC = 10;
    logic        clock_i, rst_n_i, ce_i, psel, penable, pwrite, pready;
    logic        pslverr, mains_ok_i, ctrl_supply_ok_i, bus_below_low_i;
    logic        bus_above_high_i, uv_alarm_i, servo_off_command_i;
    logic        servo_ready_o, motor_power_o, uv_warning_o, stop_req;
    logic        overspeed_alarm_o, overload_alarm_o, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [7:0]  speed_i, load_i, force_limit_o, host_limit;
    int          failures = 0;
    int          compares = 0;

    power_dip_ride_through #(.MS_CYCLES(MSC)) u_dut (
        .clock_i, .rst_n_i, .ce_i, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mains_ok_i,
        .ctrl_supply_ok_i, .bus_below_low_i, .bus_above_high_i,
        .uv_alarm_i, .speed_i, .load_i, .servo_off_command_i,
        .servo_ready_o, .motor_power_o, .uv_warning_o, .overspeed_alarm_o,
        .overload_alarm_o, .force_limit_o);
    host_model u_host (.clock_i, .rst_n_i, .uv_warning_i(uv_warning_o),
        .stop_req_i(stop_req), .servo_off_command_o(servo_off_command_i),
        .host_limit_o(host_limit));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check("read", e, rdata);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    task automatic t_registers();
        rd(`OFF_HOLD, 20);
        rd(`OFF_MAXSPD, 50);
        rd(`OFF_UVMODE, 0);
        rd(`OFF_DIPLIM, 50);
        rd(`OFF_RELTIME, 100);
        rd(`OFF_FLIM, 100);
        rd(12'h040, 0);
        check("slverr", 1, rerr);
        wr(`OFF_HOLD, 5);
        rd(`OFF_HOLD, 20);
        wr(`OFF_HOLD, 2000);
        rd(`OFF_HOLD, 1000);
        wr(`OFF_HOLD, 32'h10005);
        rd(`OFF_HOLD, 1000);
        wr(`OFF_MAXSPD, 0);
        rd(`OFF_MAXSPD, 1);
        wr(`OFF_DIPLIM, 200);
        rd(`OFF_DIPLIM, 100);
        wr(`OFF_RELTIME, 5000);
        rd(`OFF_RELTIME, 1000);
    endtask

    task automatic t_dips();
        logic dropped;
        dropped = 1'b0;
        wr(`OFF_HOLD, 20);
        @(posedge clock_i) mains_ok_i <= 1'b0;
        repeat (15 * MSC) begin
            @(negedge clock_i);
            dropped = dropped | !motor_power_o | !servo_ready_o;
        end
        check("short dip", 0, dropped);
        @(posedge clock_i) mains_ok_i <= 1'b1;
        settle(10);
        @(posedge clock_i) mains_ok_i <= 1'b0;
        settle(30 * MSC);
        check("dip power", 0, motor_power_o);
        check("dip ready", 0, servo_ready_o);
        @(posedge clock_i) mains_ok_i <= 1'b1;
        settle(10);
        check("restored", 1, motor_power_o);
    endtask

    task automatic t_cuts();
        wr(`OFF_HOLD, 1000);
        @(posedge clock_i) mains_ok_i <= 1'b0;
        uv_alarm_i <= 1'b1;
        settle(10);
        check("alarm ready", 0, servo_ready_o);
        @(posedge clock_i) mains_ok_i <= 1'b1;
        uv_alarm_i       <= 1'b0;
        ctrl_supply_ok_i <= 1'b0;
        settle(10);
        check("ctrl loss", 0, servo_ready_o);
        @(posedge clock_i) ctrl_supply_ok_i <= 1'b1;
        settle(10);
        @(posedge clock_i) stop_req <= 1'b1;
        settle(5);
        check("stop power", 0, motor_power_o);
        check("stop ready", 1, servo_ready_o);
        @(posedge clock_i) stop_req <= 1'b0;
    endtask

    task automatic t_alarms();
        wr(`OFF_MAXSPD, 10);
        @(posedge clock_i) speed_i <= 8'd11;
        settle(5);
        check("old limit", 0, overspeed_alarm_o);
        wr(`OFF_CTRL, 1);
        settle(5);
        check("new limit", 1, overspeed_alarm_o);
        @(posedge clock_i) speed_i <= 8'd10;
        wr(`OFF_CTRL, 1);
        settle(5);
        check("at limit", 0, overspeed_alarm_o);
        @(posedge clock_i) speed_i <= 8'hff;
        load_i <= 8'd200;
        settle(5);
        check("load at", 0, overload_alarm_o);
        @(posedge clock_i) load_i <= 8'd201;
        speed_i <= 8'd0;
        settle(5);
        check("load over", 1, overload_alarm_o);
    endtask

    task automatic t_modes();
        wr(`OFF_DIPLIM, 30);
        wr(`OFF_RELTIME, 5);
        // Codes 3, 0, 1, 2: the reserved code acts as off, ramp runs last
        for (int m = 3; m < 7; m++) begin
            int k;
            k = m % 4;
            wr(`OFF_UVMODE, k);
            wr(`OFF_CTRL, 1);
            @(posedge clock_i) bus_below_low_i <= 1'b1;
            settle(6);
            check("warning", k inside {1, 2}, uv_warning_o);
            check("force", k == 2 ? 30 : 100, force_limit_o);
            check("host", k inside {1, 2} ? 40 : 100, host_limit);
            @(posedge clock_i) bus_below_low_i <= 1'b0;
            bus_above_high_i <= 1'b1;
            settle(6);
            check("warn clear", 0, uv_warning_o);
            @(posedge clock_i) bus_above_high_i <= 1'b0;
        end
        settle(2 * MSC);
        check("ramp mid", 1,
              force_limit_o > 8'd30 && force_limit_o < 8'd100);
        settle(6 * MSC);
        check("ramp end", 32'd100, force_limit_o);
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        tally_and_finish();
    end

    initial begin
        {rst_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
        {bus_below_low_i, bus_above_high_i, uv_alarm_i, stop_req} = '0;
        {speed_i, load_i} = '0;
        {ce_i, mains_ok_i, ctrl_supply_ok_i} = '1;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        settle(6);
        t_registers();
        t_dips();
        t_cuts();
        t_alarms();
        t_modes();
        tally_and_finish();
    end
endmodule
